// file: verilog/uarx_pkg.sv
/*
 * Constants, field layout, state record and reset image of the serial channel.
 * Assumes a single 10 MHz clock and one AHB-Lite master in front of the block.
 */
// How it works
// [RULE_01] bit time is M times (divisor plus two)
// [RULE_02] default mode: M is sixteen
// [RULE_03] divider mode: M is X plus one, X>=8
// [RULE_04] single-ratio mode: M is one, divisor>=3
// [RULE_05] transmit and receive FIFOs of fixed depth
// [RULE_06] seven interrupt causes are reported
// [RULE_07] parity, framing, break, buffer errors readable
// [RULE_08] receive only while request-to-send asserted
// [RULE_09] request-to-send drops at flow trigger level
// [RULE_10] transmit only while clear-to-send low
// [RULE_11] function select bit one selects infrared; here only code 2 does, code 3 with bit one set selects RS-485
// [RULE_12] infrared frames are eight data, one stop
// [RULE_13] infrared is half duplex only
// [RULE_14] software waits 10 ms before infrared receive
// [RULE_15] LIN mode frames are eight data, one stop
// [RULE_16] RS-485: nine bits, request-to-send enables driver
// [RULE_17] five to eight data bits
// [RULE_18] even, odd, none or stick parity
// [RULE_19] one, one and half, two stop bits
// [RULE_20] seven-bit receive timeout count
// [RULE_21] start on falling edge, sample mid-bit
// [RULE_22] reset empties FIFOs, clears status, idles high
package uarx_pkg;
	localparam int DEPTH = 16;
	localparam int PTR_W = 4;
	localparam int CNT_W = 5;
	localparam int DW = 9;
	localparam int PW = 21;
	localparam logic [CNT_W-1:0] FIFO_FULL = 5'h10;
	// register byte offsets
	localparam logic [7:0] OFS_DATA = 8'h00;
	localparam logic [7:0] OFS_FCR = 8'h04;
	localparam logic [7:0] OFS_LCR = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0C;
	localparam logic [7:0] OFS_BAUD = 8'h10;
	localparam logic [7:0] OFS_TOUT = 8'h14;
	localparam logic [7:0] OFS_FUN = 8'h18;
	// field positions
	localparam int FCR_RXRST = 0;
	localparam int FCR_TXRST = 1;
	localparam int FCR_RTHR = 4;
	localparam int FCR_FLOW = 16;
	localparam int LCR_NSB = 2;
	localparam int LCR_PEN = 3;
	localparam int LCR_EPE = 4;
	localparam int LCR_SPE = 5;
	localparam int LCR_RTS = 6;
	localparam int LCR_ARTS = 7;
	localparam int LCR_ACTS = 8;
	localparam int BAUD_DIVX = 24;
	localparam int BAUD_ONE = 28;
	localparam int BAUD_EN = 29;
	localparam int ST_PE = 0;
	localparam int ST_FE = 1;
	localparam int ST_BI = 2;
	localparam int ST_BUF = 3;
	localparam int ST_TOUT = 4;
	localparam int ST_MODEM = 5;
	localparam int ST_LIN = 6;
	// function select codes
	localparam logic [1:0] FUN_UART = 2'h0;
	localparam logic [1:0] FUN_LIN = 2'h1;
	localparam logic [1:0] FUN_IRDA = 2'h2;
	localparam logic [1:0] FUN_RS485 = 2'h3;
	// timing figures
	localparam logic [4:0] OVS_M0 = 5'h10;
	localparam logic [PW-1:0] BRD_OFS = 21'h000002;
	localparam int IR_SHIFT = 4;
	// reset values
	localparam logic [8:0] LCR_RST = 9'h003;
	localparam logic [6:0] TOUT_RST = 7'h40;

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} uarx_txs_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} uarx_rxs_t;

	typedef struct packed {
		logic sout;
		logic rts_n;
	} uarx_line_t;

	typedef struct packed {
		uarx_txs_t txs;
		uarx_rxs_t rxs;
		logic [PW-1:0] tx_cnt, rx_cnt, ir_str;
		logic [3:0] tx_bit, rx_bit;
		logic [DW-1:0] tx_sh, rx_sh;
		logic tx_pb, rx_pb;
		logic [DEPTH-1:0][DW-1:0] txf, rxf;
		logic [PTR_W-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
		logic [CNT_W-1:0] tx_n, rx_n;
		logic [3:0] rthr, flow, divx;
		logic [8:0] lcr;
		logic [15:0] baud_divisor;
		logic div_one, div_en;
		logic [6:0] tout_lim, tout_cnt, st, cause;
		logic [1:0] fun;
		logic sin1, sin2, cts1, cts2, cts3;
		uarx_line_t line;
		logic a_wr;
		logic [7:0] a_addr;
		logic [31:0] hrdata;
	} uarx_state_t;

	localparam uarx_state_t ST_RST = '{txs: TX_IDLE, rxs: RX_IDLE, lcr: LCR_RST,
		tout_lim: TOUT_RST, sin1: 1'b1, sin2: 1'b1, cts1: 1'b1, cts2: 1'b1, cts3: 1'b1,
		line: 2'h3, default: '0};
endpackage

// file: verilog/uarx_top.sv
/*
 * Serial channel with FIFOs, baud generator, flow control and the
 * infrared, LIN and RS-485 alternate framings, behind an AHB-Lite slave.
 * Assumes sin and cts_n arrive asynchronously from pins and that the
 * infrared receiver delivers active-high pulses on sin.
 */
`timescale 1ns/1ps
module uarx_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic sin,
	input wire logic cts_n,
	output uarx_pkg::uarx_line_t line,
	output logic [6:0] cause
);
	uarx_pkg::uarx_state_t st_q, st_d;
	logic special, irda, lin, rs485, has_par, stop2, rx_line, rx_ok, tx_b;
	logic push_tx, pop_tx, push_rx, pop_rx, tx_flush, rx_flush, tick;
	logic [3:0] nbits;
	logic [4:0] ovs;
	logic [uarx_pkg::PW-1:0] per, half, stop_len, ir_w;
	logic [uarx_pkg::PW:0] ir_prod;
	logic [uarx_pkg::DW-1:0] rx_word;
	logic [6:0] set, clr;

	// parity over the low n bits of a character
	function automatic logic par_of(input logic [8:0] v, input logic [3:0] n);
		logic p;
		p = 1'b0;
		for (int i = 0; i < 9; i++) begin
			if (i < int'(n)) begin
				p = p ^ v[i];
			end
		end
		return p;
	endfunction

	// frame shape per function mode
	assign lin = st_q.fun == uarx_pkg::FUN_LIN;
	assign irda = st_q.fun == uarx_pkg::FUN_IRDA; // RULE_11
	assign rs485 = st_q.fun == uarx_pkg::FUN_RS485;
	assign special = st_q.fun != uarx_pkg::FUN_UART;
	assign nbits = special ? 4'h8 : 4'h5 + {2'h0, st_q.lcr[1:0]}; // RULE_12 RULE_15 RULE_17
	assign has_par = rs485 | (!special & st_q.lcr[uarx_pkg::LCR_PEN]); // RULE_16 RULE_18
	assign stop2 = st_q.lcr[uarx_pkg::LCR_NSB] & !special;

	// bit time in clocks; divisor limits of the divider modes are left to software
	assign ovs = !st_q.div_en ? uarx_pkg::OVS_M0 : // RULE_02
		(st_q.div_one ? 5'h01 : {1'b0, st_q.divx} + 5'h01); // RULE_03 RULE_04
	assign per = {16'h0000, ovs} * ({5'h00, st_q.baud_divisor} + uarx_pkg::BRD_OFS); // RULE_01
	assign half = per >> 1;
	assign stop_len = !stop2 ? per : (nbits == 4'h5 ? per + half : per << 1); // RULE_19
	assign ir_prod = {1'b0, per} + {per, 1'b0};
	assign ir_w = uarx_pkg::PW'(ir_prod >> uarx_pkg::IR_SHIFT);
	// infrared pulse is stretched into a low level; else the synced pin
	assign rx_line = irda ? (st_q.ir_str == '0) : st_q.sin2;
	// receiver gated by flow control and by a busy infrared transmitter
	assign rx_ok = !(st_q.lcr[uarx_pkg::LCR_ARTS] & st_q.line.rts_n) // RULE_08
		& !(irda & st_q.txs != uarx_pkg::TX_IDLE); // RULE_13

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = st_q.hrdata;
	assign line = st_q.line;
	assign cause = st_q.cause;

	// next-state of the whole channel
	always_comb begin
		st_d = st_q;
		set = '0;
		clr = '0;
		push_tx = 1'b0;
		pop_tx = 1'b0;
		push_rx = 1'b0;
		pop_rx = 1'b0;
		tx_flush = 1'b0;
		rx_flush = 1'b0;
		tick = 1'b0;
		rx_word = '0;
		tx_b = 1'b1;
		// two-flop synchronisers; cts3 only feeds the change detector
		st_d.sin1 = sin;
		st_d.sin2 = st_q.sin1;
		st_d.cts1 = cts_n;
		st_d.cts2 = st_q.cts1;
		st_d.cts3 = st_q.cts2;
		if (st_q.cts2 != st_q.cts3) begin
			set[uarx_pkg::ST_MODEM] = 1'b1; // RULE_06
		end

		// bus address phase: read data is prepared here for the data phase
		st_d.a_wr = 1'b0;
		if (hsel && htrans[1] && hready) begin
			st_d.a_wr = hwrite;
			st_d.a_addr = haddr[7:0];
			if (!hwrite) begin
				unique case (haddr[7:0])
					uarx_pkg::OFS_DATA: begin
						st_d.hrdata = {23'h0, st_q.rxf[st_q.rx_rp]};
						pop_rx = st_q.rx_n != '0;
					end
					uarx_pkg::OFS_FCR: begin
						st_d.hrdata = {12'h0, st_q.flow, 8'h0, st_q.rthr, 4'h0};
					end
					uarx_pkg::OFS_LCR: begin
						st_d.hrdata = {23'h0, st_q.lcr};
					end
					uarx_pkg::OFS_STAT: begin
						st_d.hrdata = {6'h0, st_q.cts2, st_q.txs != uarx_pkg::TX_IDLE, 3'h0,
							st_q.tx_n, 3'h0, st_q.rx_n, 1'b0, st_q.st}; // RULE_07
					end
					uarx_pkg::OFS_BAUD: begin
						st_d.hrdata = {2'h0, st_q.div_en, st_q.div_one, st_q.divx, 8'h0,
							st_q.baud_divisor};
					end
					uarx_pkg::OFS_TOUT: begin
						st_d.hrdata = {25'h0, st_q.tout_lim};
					end
					uarx_pkg::OFS_FUN: begin
						st_d.hrdata = {30'h0, st_q.fun};
					end
					default: begin
						st_d.hrdata = '0;
					end
				endcase
			end
		end

		// bus data phase for writes
		if (st_q.a_wr) begin
			unique case (st_q.a_addr)
				uarx_pkg::OFS_DATA: begin
					push_tx = 1'b1;
				end
				uarx_pkg::OFS_FCR: begin
					rx_flush = hwdata[uarx_pkg::FCR_RXRST];
					tx_flush = hwdata[uarx_pkg::FCR_TXRST];
					st_d.rthr = hwdata[uarx_pkg::FCR_RTHR +: 4];
					st_d.flow = hwdata[uarx_pkg::FCR_FLOW +: 4];
				end
				uarx_pkg::OFS_LCR: begin
					st_d.lcr = hwdata[8:0];
				end
				uarx_pkg::OFS_STAT: begin
					clr = hwdata[6:0];
				end
				uarx_pkg::OFS_BAUD: begin
					st_d.baud_divisor = hwdata[15:0];
					st_d.divx = hwdata[uarx_pkg::BAUD_DIVX +: 4];
					st_d.div_one = hwdata[uarx_pkg::BAUD_ONE];
					st_d.div_en = hwdata[uarx_pkg::BAUD_EN];
				end
				uarx_pkg::OFS_TOUT: begin
					st_d.tout_lim = hwdata[6:0];
				end
				uarx_pkg::OFS_FUN: begin
					st_d.fun = hwdata[1:0];
				end
				default: begin
				end
			endcase
		end

		// infrared decoder: a pulse holds the line low for most of a bit
		if (irda && st_q.sin2) begin
			st_d.ir_str = per - (per >> 3);
		end else if (st_q.ir_str != '0) begin
			st_d.ir_str = st_q.ir_str - 1'b1;
		end

		// receiver
		st_d.rx_cnt = st_q.rx_cnt - 1'b1;
		unique case (st_q.rxs)
			uarx_pkg::RX_IDLE: begin
				if (st_q.rx_cnt == '0) begin
					st_d.rx_cnt = per - 1'b1;
					tick = 1'b1; // free-running bit time for the timeout
				end
				if (!rx_line && rx_ok) begin
					st_d.rxs = uarx_pkg::RX_START; // RULE_21
					st_d.rx_cnt = half;
					st_d.rx_sh = '0;
				end
			end
			uarx_pkg::RX_START: begin
				if (st_q.rx_cnt == '0) begin
					// a high line at mid start bit is a glitch
					st_d.rxs = rx_line ? uarx_pkg::RX_IDLE : uarx_pkg::RX_DATA; // RULE_21
					st_d.rx_cnt = per - 1'b1;
					st_d.rx_bit = '0;
				end
			end
			uarx_pkg::RX_DATA: begin
				if (st_q.rx_cnt == '0) begin
					st_d.rx_sh[st_q.rx_bit] = rx_line; // RULE_21
					st_d.rx_cnt = per - 1'b1;
					st_d.rx_bit = st_q.rx_bit + 1'b1;
					if (st_q.rx_bit == nbits - 1'b1) begin
						st_d.rxs = has_par ? uarx_pkg::RX_PAR : uarx_pkg::RX_STOP;
					end
				end
			end
			uarx_pkg::RX_PAR: begin
				if (st_q.rx_cnt == '0) begin
					st_d.rx_pb = rx_line;
					st_d.rx_cnt = per - 1'b1;
					st_d.rxs = uarx_pkg::RX_STOP;
				end
			end
			uarx_pkg::RX_STOP: begin
				if (st_q.rx_cnt == '0) begin
					st_d.rxs = uarx_pkg::RX_IDLE;
					st_d.rx_cnt = '0;
					push_rx = 1'b1;
					rx_word = {rs485 & st_q.rx_pb, st_q.rx_sh[7:0]}; // RULE_16
					set[uarx_pkg::ST_FE] = !rx_line; // RULE_07
					if (has_par && !rs485) begin
						set[uarx_pkg::ST_PE] = st_q.rx_pb != (st_q.lcr[uarx_pkg::LCR_SPE] ?
							!st_q.lcr[uarx_pkg::LCR_EPE] :
							par_of(st_q.rx_sh, nbits) ^ !st_q.lcr[uarx_pkg::LCR_EPE]); // RULE_18
					end
					if (!rx_line && st_q.rx_sh == '0 && !(has_par && st_q.rx_pb)) begin
						set[uarx_pkg::ST_BI] = 1'b1; // RULE_07
						set[uarx_pkg::ST_LIN] = lin; // RULE_06
					end
				end
			end
		endcase

		// receive timeout counted in bit times while data waits unread
		if (st_q.rx_n == '0 || st_q.rxs != uarx_pkg::RX_IDLE || pop_rx) begin
			st_d.tout_cnt = '0;
		end else if (tick && st_q.tout_cnt != st_q.tout_lim) begin
			st_d.tout_cnt = st_q.tout_cnt + 1'b1; // RULE_20
			set[uarx_pkg::ST_TOUT] = st_q.tout_cnt + 1'b1 == st_q.tout_lim; // RULE_20
		end

		// transmitter
		st_d.tx_cnt = st_q.tx_cnt - 1'b1;
		unique case (st_q.txs)
			uarx_pkg::TX_IDLE: begin
				st_d.tx_cnt = '0;
				if (st_q.tx_n != '0
					&& !(st_q.lcr[uarx_pkg::LCR_ACTS] && st_q.cts2) // RULE_10
					&& !(irda && st_q.rxs != uarx_pkg::RX_IDLE)) begin // RULE_13
					pop_tx = 1'b1;
					st_d.tx_sh = st_q.txf[st_q.tx_rp];
					st_d.tx_pb = rs485 ? st_q.txf[st_q.tx_rp][8] : // RULE_16
						(st_q.lcr[uarx_pkg::LCR_SPE] ? !st_q.lcr[uarx_pkg::LCR_EPE] :
						par_of(st_q.txf[st_q.tx_rp], nbits) ^
						!st_q.lcr[uarx_pkg::LCR_EPE]); // RULE_18
					st_d.txs = uarx_pkg::TX_START;
					st_d.tx_cnt = per - 1'b1;
				end
			end
			uarx_pkg::TX_START: begin
				if (st_q.tx_cnt == '0) begin
					st_d.txs = uarx_pkg::TX_DATA;
					st_d.tx_bit = '0;
					st_d.tx_cnt = per - 1'b1;
				end
			end
			uarx_pkg::TX_DATA: begin
				if (st_q.tx_cnt == '0) begin
					st_d.tx_bit = st_q.tx_bit + 1'b1;
					st_d.tx_cnt = per - 1'b1;
					if (st_q.tx_bit == nbits - 1'b1) begin
						st_d.txs = has_par ? uarx_pkg::TX_PAR : uarx_pkg::TX_STOP;
						st_d.tx_cnt = has_par ? per - 1'b1 : stop_len - 1'b1; // RULE_19
					end
				end
			end
			uarx_pkg::TX_PAR: begin
				if (st_q.tx_cnt == '0) begin
					st_d.txs = uarx_pkg::TX_STOP;
					st_d.tx_cnt = stop_len - 1'b1; // RULE_19
				end
			end
			uarx_pkg::TX_STOP: begin
				if (st_q.tx_cnt == '0) begin
					st_d.txs = uarx_pkg::TX_IDLE;
				end
			end
		endcase

		// FIFO bookkeeping; a push into a full FIFO is lost and flagged
		if (push_tx) begin
			if (st_q.tx_n == uarx_pkg::FIFO_FULL) begin
				set[uarx_pkg::ST_BUF] = 1'b1; // RULE_07
			end else begin
				st_d.txf[st_q.tx_wp] = hwdata[8:0]; // RULE_05
				st_d.tx_wp = st_q.tx_wp + 1'b1;
			end
		end
		if (push_rx) begin
			if (st_q.rx_n == uarx_pkg::FIFO_FULL) begin
				set[uarx_pkg::ST_BUF] = 1'b1; // RULE_07
			end else begin
				st_d.rxf[st_q.rx_wp] = rx_word; // RULE_05
				st_d.rx_wp = st_q.rx_wp + 1'b1;
			end
		end
		st_d.tx_rp = st_q.tx_rp + {3'h0, pop_tx};
		st_d.rx_rp = st_q.rx_rp + {3'h0, pop_rx};
		st_d.tx_n = st_q.tx_n - {4'h0, pop_tx} +
			{4'h0, push_tx && st_q.tx_n != uarx_pkg::FIFO_FULL};
		st_d.rx_n = st_q.rx_n - {4'h0, pop_rx} +
			{4'h0, push_rx && st_q.rx_n != uarx_pkg::FIFO_FULL};
		if (tx_flush) begin
			st_d.tx_wp = '0;
			st_d.tx_rp = '0;
			st_d.tx_n = '0;
		end
		if (rx_flush) begin
			st_d.rx_wp = '0;
			st_d.rx_rp = '0;
			st_d.rx_n = '0;
		end

		// sticky status: a new event beats a clear in the same cycle
		st_d.st = (st_q.st & ~clr) | set;
		st_d.cause = {st_d.st[uarx_pkg::ST_LIN], st_d.st[uarx_pkg::ST_BUF],
			st_d.st[uarx_pkg::ST_MODEM], st_d.st[uarx_pkg::ST_TOUT],
			|st_d.st[uarx_pkg::ST_BI:uarx_pkg::ST_PE],
			st_d.rx_n != '0 && st_d.rx_n >= {1'b0, st_d.rthr},
			st_d.tx_n == '0}; // RULE_06

		// line level from the next transmit state
		unique case (st_d.txs)
			uarx_pkg::TX_IDLE: tx_b = 1'b1;
			uarx_pkg::TX_START: tx_b = 1'b0;
			uarx_pkg::TX_DATA: tx_b = st_d.tx_sh[st_d.tx_bit];
			uarx_pkg::TX_PAR: tx_b = st_d.tx_pb;
			uarx_pkg::TX_STOP: tx_b = 1'b1;
		endcase
		// infrared sends a 3/16 pulse for each zero, nothing for a one
		st_d.line.sout = irda ? (!tx_b && st_d.txs != uarx_pkg::TX_IDLE
			&& st_d.tx_cnt >= per - ir_w) : tx_b; // RULE_11
		if (rs485) begin
			st_d.line.rts_n = st_d.txs == uarx_pkg::TX_IDLE; // RULE_16
		end else if (st_d.lcr[uarx_pkg::LCR_ARTS]) begin
			st_d.line.rts_n = st_d.rx_n >= {1'b0, st_d.flow}; // RULE_09
		end else begin
			st_d.line.rts_n = !st_d.lcr[uarx_pkg::LCR_RTS];
		end
	end

	// single state register; reset empties FIFOs and idles the line high
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= uarx_pkg::ST_RST; // RULE_22
		end else begin
			st_q <= st_d;
		end
	end
endmodule

// file: test/uarx_sva.sv
/* Port-level checks of the serial channel.
 * Assumes binding to the top module, one clock, async active-low reset. */
`timescale 1ns/1ps
module uarx_sva (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire uarx_pkg::uarx_line_t line,
	input wire logic [6:0] cause
);
	logic fw_q, fw_d;
	logic [1:0] fun_q, fun_d;
	// mode shadow, needed because the mode is not visible at the ports
	always_comb begin
		fw_d = hsel && htrans[1] && hwrite && haddr[7:0] == uarx_pkg::OFS_FUN;
		fun_d = fw_q ? hwdata[1:0] : fun_q;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fw_q <= 1'b0;
			fun_q <= uarx_pkg::FUN_UART;
		end else begin
			fw_q <= fw_d;
			fun_q <= fun_d;
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	ready_high_a: assert property (hreadyout)
		else $error("bus stalled");
	resp_okay_a: assert property (!hresp)
		else $error("error response");
	reset_idle_a: assert property ($rose(hresetn) |-> line == 2'h3 && cause == 7'h00)
		else $error("line not idle after reset");
	empty_flag_a: assert property ($rose(hresetn) |=> cause[0])
		else $error("tx empty cause missing");
	bit_hold_a: assert property ($fell(line.sout) |-> !line.sout [*4])
		else $error("low bit too short");
	gap_read_a: assert property (hsel && htrans[1] && !hwrite &&
		haddr[7:0] == 8'h1C |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	stat_bits_a: assert property (hsel && htrans[1] && !hwrite &&
		haddr[7:0] == uarx_pkg::OFS_STAT |=> (hrdata & 32'hFCE0E080) == 32'h0)
		else $error("status spare bits set");
	data_width_a: assert property (hsel && htrans[1] && !hwrite &&
		haddr[7:0] == uarx_pkg::OFS_DATA |=> hrdata[31:9] == 23'h0)
		else $error("data upper bits set");
	rts_drive_a: assert property (fun_q == uarx_pkg::FUN_RS485 &&
		$fell(line.sout) |-> ##1 !line.rts_n)
		else $error("driver not enabled");
endmodule
bind uarx_top uarx_sva chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .line(line), .cause(cause));

// file: test/uarx_peer.sv
/* Far-side serial device: sends and captures frames, drives clear-to-send.
 * Assumes bit times given in bench clocks. */
`timescale 1ns/1ps
module uarx_peer (
	input wire logic clk,
	input wire logic sout,
	input wire logic hold,
	output logic sin,
	output logic cts_n
);
	// idle line rests high, as with a pull-up
	initial sin = 1'b1;
	// far end gates our transmitter
	assign cts_n = hold;
	// start bit, then n bits lsb first
	task automatic send(input logic [11:0] v, input int n, t);
		sin <= 1'b0;
		repeat (t) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			sin <= v[i];
			repeat (t) @(posedge clk);
		end
		sin <= 1'b1;
	endtask
	// mid-bit sampling from the falling start edge
	task automatic recv(input int t, n, output logic [11:0] v);
		v = '0;
		@(negedge sout);
		repeat (t / 2) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			repeat (t) @(posedge clk);
			v[i] = sout;
		end
	endtask
endmodule

// file: test/uarx_top_tb.sv
/* Bench for the serial channel: bus master tasks, random frames, far-side peer.
 * Assumes the peer model and the bound checker are compiled with it. */
`timescale 1ns/1ps
module uarx_top_tb;
	logic hclk, hresetn, hsel, hwrite, hold, hreadyout, hresp, sin, cts_n;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [6:0] cause;
	logic [7:0] sd, f;
	logic [8:0] c;
	logic [11:0] v, e;
	uarx_pkg::uarx_line_t line;
	int fails, samples_checked, cyc, n;
	// software keeps X at 8 or more and A at 3 or more
	logic [31:0] bw [3] = '{32'h00000000, 32'h28000000, 32'h30000003};
	int bt [3] = '{32, 18, 5};
	uarx_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.sin(sin), .cts_n(cts_n), .line(line), .cause(cause));
	uarx_peer peer (.clk(hclk), .sout(line.sout), .hold(hold), .sin(sin), .cts_n(cts_n));
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	// hang guard, far above the few thousand cycles needed
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			fails++;
			end_sim();
		end
	end
	function automatic logic [7:0] nx(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// serial bits after the start bit, lsb first, and their count
	function automatic logic [11:0] fexp(input logic [8:0] c, input logic [7:0] d, output int k);
		logic [7:0] m;
		logic p;
		m = d & (8'hFF >> (3 - c[1:0]));
		p = c[5] ? ~c[4] : (c[4] ? ^m : ~^m);
		k = c[1:0] + 5;
		fexp = {4'h0, m};
		if (c[3]) begin
			fexp[k] = p;
			k++;
		end
		fexp |= (c[2] ? 12'h3 : 12'h1) << k;
		k += 1 + c[2];
	endfunction
	task automatic chk(input logic [31:0] s, x);
		samples_checked++;
		if (s !== x) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, s, x);
		end
	endtask
	// one single transfer; read data lands in r
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] m, x);
		bus(1'b0, a, 32'h0);
		chk(r & m, x);
	endtask
	// poll status until the masked field matches
	task automatic pw(input logic [31:0] m, x);
		r = ~x;
		for (int i = 0; i < 400 && (r & m) !== x; i++)
			bus(1'b0, uarx_pkg::OFS_STAT, 32'h0);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		hold = 1'b1;
		sd = 8'h30;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		// reset image: idle line, empty fifos, default framing
		chk({line, cause}, 9'h181);
		rc(uarx_pkg::OFS_LCR, 32'h1FF, 32'h3);
		rc(uarx_pkg::OFS_TOUT, 32'h7F, 32'h40);
		rc(uarx_pkg::OFS_STAT, 32'hFFFFFFFF, 32'h02000000);
		rc(8'h1C, 32'hFFFFFFFF, 32'h0);
		// each divider mode with random framing and data
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, uarx_pkg::OFS_BAUD, bw[i]);
			repeat (3) begin
				sd = nx(sd);
				c = {3'h0, sd[5:0]};
				c[2] = c[2] & (c[1:0] != 2'h0);
				sd = nx(sd);
				e = fexp(c, sd, n);
				bus(1'b1, uarx_pkg::OFS_LCR, {23'h0, c});
				bus(1'b1, uarx_pkg::OFS_DATA, {24'h0, sd});
				peer.recv(bt[i], n, v);
				chk(v, e);
			end
		end
		// receive clean byte, bad parity, then a break
		bus(1'b1, uarx_pkg::OFS_BAUD, bw[1]);
		bus(1'b1, uarx_pkg::OFS_LCR, 32'h1B);
		for (int k = 0; k < 3; k++) begin
			sd = nx(sd);
			v = (k == 2) ? 12'h0 : {3'h1, (k == 1) ^ (^sd), sd};
			peer.send(v, 10, 18);
			pw(32'h1F00, 32'h0100);
			bus(1'b0, uarx_pkg::OFS_DATA, 32'h0);
			if (k < 2) chk(r[7:0], sd);
			rc(uarx_pkg::OFS_STAT, 32'h7, (k == 0) ? 32'h0 : (k == 1) ? 32'h1 : 32'h6);
			chk(cause[2], k != 0);
			bus(1'b1, uarx_pkg::OFS_STAT, 32'h7F);
		end
		// unread byte ages past a two-bit-time limit
		bus(1'b1, uarx_pkg::OFS_TOUT, 32'h2);
		peer.send({3'h1, ^sd, sd}, 10, 18);
		pw(32'h1F00, 32'h0100);
		repeat (72) @(posedge hclk);
		rc(uarx_pkg::OFS_STAT, 32'h17, 32'h10);
		chk(cause[3:1], 3'h5);
		// auto request-to-send, trigger level two, third byte refused
		bus(1'b1, uarx_pkg::OFS_FCR, 32'h00020001);
		bus(1'b1, uarx_pkg::OFS_LCR, 32'h9B);
		rc(uarx_pkg::OFS_STAT, 32'h1F00, 32'h0);
		chk(line.rts_n, 1'b0);
		repeat (3) peer.send({3'h1, ^sd, sd}, 10, 18);
		rc(uarx_pkg::OFS_STAT, 32'h1F00, 32'h0200);
		chk(line.rts_n, 1'b1);
		// held off by clear-to-send, overfill the transmit fifo
		bus(1'b1, uarx_pkg::OFS_FCR, 32'h3);
		bus(1'b1, uarx_pkg::OFS_LCR, 32'h103);
		f = sd;
		for (int k = 0; k < 17; k++) begin
			bus(1'b1, uarx_pkg::OFS_DATA, {24'h0, sd});
			sd = nx(sd);
		end
		rc(uarx_pkg::OFS_STAT, 32'h1F0008, 32'h100008);
		chk(line.sout, 1'b1);
		hold <= 1'b0;
		peer.recv(18, 9, v);
		chk(v, {4'h1, f});
		bus(1'b1, uarx_pkg::OFS_FCR, 32'h2);
		rc(uarx_pkg::OFS_STAT, 32'h1F0000, 32'h0);
		// overflow and the clear-to-send change are both still pending
		rc(uarx_pkg::OFS_STAT, 32'h28, 32'h28);
		chk(cause[5:4], 2'h3);
		pw(32'h01000000, 32'h0);
		// LIN and RS-485 keep eight data bits despite a five-bit setting
		bus(1'b1, uarx_pkg::OFS_LCR, 32'h0);
		for (int k = 0; k < 2; k++) begin
			bus(1'b1, uarx_pkg::OFS_FUN, 32'(k ? uarx_pkg::FUN_RS485 : uarx_pkg::FUN_LIN));
			bus(1'b1, uarx_pkg::OFS_DATA, 32'h1A5);
			peer.recv(18, 9 + k, v);
			chk(v, k ? 12'h3A5 : 12'h1A5);
			// LIN break: ten low bit times, line back high before a false start
			if (k == 0) begin
				peer.send(12'h0, 9, 18);
				pw(32'h1F00, 32'h0100);
				rc(uarx_pkg::OFS_STAT, 32'h46, 32'h46);
				chk(cause[6], 1'b1);
				rc(uarx_pkg::OFS_DATA, 32'h1FF, 32'h0);
				bus(1'b1, uarx_pkg::OFS_STAT, 32'h7F);
			end
		end
		peer.send({3'h1, 1'b1, sd}, 10, 18);
		pw(32'h1F00, 32'h0100);
		rc(uarx_pkg::OFS_DATA, 32'h1FF, {24'h1, sd});
		// infrared idles low; no receive follows, so no turnaround wait
		bus(1'b1, uarx_pkg::OFS_FUN, 32'(uarx_pkg::FUN_IRDA));
		repeat (4) @(posedge hclk);
		chk(line.sout, 1'b0);
		end_sim();
	end
endmodule
